// ---- core/och_cfg_header.sv ----
/*
 * Front of the configuration header of the serial bus function: the
 * identity words at 00h and 02h and the command register at 04h, reached
 * by configuration reads and writes by dword index with byte enables.
 * Assumes one clock, an asynchronous active-low reset, and that the three
 * header reset sources arrive asynchronously from outside.
 */
// Function
// R1: Maker code at 00h, fixed, read-only.
// R2: Function code at 02h, fixed, read-only.
// R3: Command register at 04h resets to zero.
// R4: Command bits 15..11 read zero, ignore writes.
// R5: Bit 10 set blocks interrupt output.
// R6: No fast back-to-back; bit 9 reads zero.
// R7: Bit 8 enables system error driver.
// R8: No stepping; bit 7 hardwired zero.
// R9: Bit 6 enables parity error driver.
// R10: No palette snoop; bit 5 reads zero.
// R11: Bit 4 allows write-and-invalidate commands.
// R12: Special cycles ignored; bit 3 reads zero.
// R13: Bit 2 enables bus mastering.
// R14: Bit 1 enables memory-space response.
// R15: Host sets memory enable before register access.
// R16: No I/O decoding; bit 0 reads zero.
// R17: Three reset sources restore command defaults.
// R18: Configuration cycles decoded by dword and enables.
`timescale 1ns/1ps
module och_cfg_header
    import och_pkg::*;
#(
    parameter logic [15:0] MAKER_ID            = MAKER_ID_DEFAULT,
    parameter logic [15:0] FUNCTION_ID         = FUNCTION_ID_DEFAULT,
    parameter bit          INT_DISABLE_WRITABLE = 1'b1
)
(
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    input  wire logic                     fundamental_link_reset_n,
    input  wire logic                     global_reset_n,
    input  wire logic                     power_on_reset_n,
    input  wire logic                     cfg_rd,
    input  wire logic                     cfg_wr,
    input  wire logic [CFG_DW_ADDR_W-1:0] cfg_dword_addr,
    input  wire logic [3:0]               cfg_byte_en,
    input  wire logic [31:0]              cfg_wdata,
    output logic      [31:0]              cfg_rdata,
    output logic                          cfg_ack,
    input  wire logic                     irq_request,
    input  wire logic                     addr_parity_error,
    input  wire logic                     data_parity_error,
    input  wire logic                     master_request,
    input  wire logic                     master_write_inv,
    input  wire logic                     mem_decode_hit,
    output logic                          interrupt_out,
    output logic                          system_error_output_n,
    output logic                          system_error_output_oe,
    output logic                          parity_error_output_n,
    output logic                          parity_error_output_oe,
    output logic                          master_grant,
    output logic      [3:0]               master_cmd,
    output logic                          mem_claim
);

    // The interrupt disable bit is kept writable by default, since a bit
    // that can never leave zero could not perform its gating role.
    localparam logic [15:0] CMD_WR_MASK = INT_DISABLE_WRITABLE ?
                                          (CMD_WR_MASK_BASE | CMD_INT_DIS_MASK) :
                                          CMD_WR_MASK_BASE;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic dword_hit(input logic [CFG_DW_ADDR_W-1:0] addr,
                                       input logic [5:0]               index);
        dword_hit = (addr == index[CFG_DW_ADDR_W-1:0]);
    endfunction : dword_hit

    // Byte-lane merge restricted to the writable bits of a 16-bit half.
    function automatic logic [15:0] lane_merge(input logic [15:0] old_val,
                                               input logic [15:0] new_val,
                                               input logic [1:0]  lanes,
                                               input logic [15:0] wmask);
        logic [15:0] m;
        m          = {{8{lanes[1]}}, {8{lanes[0]}}} & wmask;
        lane_merge = (old_val & ~m) | (new_val & m);
    endfunction : lane_merge

    // ************************************************************
    // Header reset sources
    // ************************************************************
    logic [2:0] rst_meta_r;
    logic [2:0] rst_sync_r;
    logic       hdr_clear;

    // Each source passes two flops; the first stage feeds only the second.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= RST_SYNC_RESET;
            rst_sync_r <= RST_SYNC_RESET;
        end else begin
            rst_meta_r <= {power_on_reset_n, global_reset_n, fundamental_link_reset_n};
            rst_sync_r <= rst_meta_r;
        end
    end

    assign hdr_clear = ~&rst_sync_r; // [R17]

    // ************************************************************
    // Access decode
    // ************************************************************
    logic        wr_control;
    logic        rd_ident;
    logic        rd_control;
    logic [15:0] command_r;
    logic [15:0] command_nxt;

    // Writes to the identity dword match no writable bit and fall away.
    assign wr_control = cfg_wr && dword_hit(cfg_dword_addr, DW_CONTROL); // [R18]
    assign rd_ident   = cfg_rd && dword_hit(cfg_dword_addr, DW_IDENT); // [R18]
    assign rd_control = cfg_rd && dword_hit(cfg_dword_addr, DW_CONTROL); // [R18]

    // Hardwired-zero bits never enter the register through the mask.
    always_comb begin
        command_nxt = command_r;
        if (wr_control) begin
            command_nxt = lane_merge(command_r, cfg_wdata[15:0], cfg_byte_en[1:0],
                                     CMD_WR_MASK); // [R4] [R6] [R8] [R10] [R12] [R16]
        end
    end

    // ************************************************************
    // Command register
    // ************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            command_r <= CMD_RESET; // [R3]
        end else if (hdr_clear) begin
            command_r <= CMD_RESET; // [R17]
        end else begin
            command_r <= command_nxt; // [R7] [R9] [R11] [R13] [R14]
        end
    end

    // ************************************************************
    // Read data and acknowledge
    // ************************************************************
    // Reads return the value held before any write taken in the same cycle.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_rdata <= RDATA_RESET;
        end else if (rd_ident) begin
            cfg_rdata <= {FUNCTION_ID, MAKER_ID}; // [R1] [R2]
        end else if (rd_control) begin
            cfg_rdata <= {STATUS_PLACEHOLD, command_r}; // [R3]
        end else if (cfg_rd) begin
            cfg_rdata <= RDATA_RESET;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_ack <= 1'b0;
        end else begin
            cfg_ack <= cfg_rd | cfg_wr; // [R18]
        end
    end

    // ************************************************************
    // Bus-side gating
    // ************************************************************
    // Memory claims stay off until the host sets the memory enable.
    och_bus_gate u_gate (
        .clk                    (clk),
        .reset_n                (reset_n),
        .command                (command_r),
        .irq_request            (irq_request),
        .addr_parity_error      (addr_parity_error),
        .data_parity_error      (data_parity_error),
        .master_request         (master_request),
        .master_write_inv       (master_write_inv),
        .mem_decode_hit         (mem_decode_hit),
        .interrupt_out          (interrupt_out),
        .system_error_output_n  (system_error_output_n),
        .system_error_output_oe (system_error_output_oe),
        .parity_error_output_n  (parity_error_output_n),
        .parity_error_output_oe (parity_error_output_oe),
        .master_grant           (master_grant),
        .master_cmd             (master_cmd),
        .mem_claim              (mem_claim)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_ident_read;
        cfg_rd && cfg_dword_addr == DW_IDENT;
    endsequence

    sequence s_low_write;
        cfg_wr && cfg_dword_addr == DW_CONTROL && cfg_byte_en[0] && !hdr_clear;
    endsequence

    sequence s_high_write;
        cfg_wr && cfg_dword_addr == DW_CONTROL && cfg_byte_en[1] && !hdr_clear;
    endsequence

    property p_maker_read;
        @(posedge clk) disable iff (!reset_n)
        s_ident_read |=> cfg_ack && cfg_rdata[15:0] == MAKER_ID;
    endproperty
    a_maker_read: assert property (p_maker_read) else $error("maker code wrong"); // [R1]

    property p_function_read;
        @(posedge clk) disable iff (!reset_n)
        s_ident_read |=> cfg_rdata[31:16] == FUNCTION_ID;
    endproperty
    a_function_read: assert property (p_function_read) else $error("function code wrong"); // [R2]

    property p_clear_zero;
        @(posedge clk) disable iff (!reset_n)
        hdr_clear |=> command_r == CMD_RESET;
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("command not cleared"); // [R17]

    property p_low_write;
        @(posedge clk) disable iff (!reset_n)
        s_low_write |=> command_r[7:0] == ($past(cfg_wdata[7:0]) & CMD_WR_MASK[7:0]);
    endproperty
    a_low_write: assert property (p_low_write) else $error("low byte write wrong"); // [R8]

    property p_high_write;
        @(posedge clk) disable iff (!reset_n)
        s_high_write |=> command_r[15:8] == ($past(cfg_wdata[15:8]) & CMD_WR_MASK[15:8]);
    endproperty
    a_high_write: assert property (p_high_write) else $error("high byte write wrong"); // [R4]

    property p_hardwired;
        @(posedge clk) disable iff (!reset_n)
        rd_control |=> cfg_rdata[CMD_RSVD_HI:CMD_RSVD_LO] == 5'h00 && !cfg_rdata[CMD_B2B]
                       && !cfg_rdata[CMD_PALETTE] && !cfg_rdata[CMD_SPECIAL];
    endproperty
    a_hardwired: assert property (p_hardwired) else $error("hardwired bit set"); // [R6]

    property p_no_io;
        @(posedge clk) disable iff (!reset_n)
        rd_control |=> !cfg_rdata[CMD_IO_SPACE] && !cfg_rdata[CMD_STEP];
    endproperty
    a_no_io: assert property (p_no_io) else $error("io or step bit set"); // [R16]

    property p_no_special;
        @(posedge clk) disable iff (!reset_n)
        !command_r[CMD_SPECIAL] && !command_r[CMD_PALETTE];
    endproperty
    a_no_special: assert property (p_no_special) else $error("special or palette set"); // [R12]

    property p_control_read;
        @(posedge clk) disable iff (!reset_n)
        rd_control |=> cfg_rdata == {STATUS_PLACEHOLD, $past(command_r)};
    endproperty
    a_control_read: assert property (p_control_read) else $error("command readback wrong"); // [R3]

    property p_no_write_keep;
        @(posedge clk) disable iff (!reset_n)
        !wr_control && !hdr_clear |=> $stable(command_r);
    endproperty
    a_no_write_keep: assert property (p_no_write_keep) else $error("command changed"); // [R18]

    property p_int_path;
        @(posedge clk) disable iff (!reset_n)
        command_r[CMD_INT_DIS] && irq_request ##1 command_r[CMD_INT_DIS] |=> !interrupt_out;
    endproperty
    a_int_path: assert property (p_int_path) else $error("interrupt leaked"); // [R5]

endmodule : och_cfg_header

// ---- shared/och_pkg.sv ----
/*
 * Constants shared by the configuration header front: offsets, command
 * register field positions, masks, reset values and bus command codes.
 * Assumes a 32-bit configuration data path addressed by dword index.
 */
package och_pkg;

    // ************************************************************
    // Configuration offsets (byte addresses), dword indices and index width
    // ************************************************************
    localparam int               CFG_DW_ADDR_W = 6;
    localparam logic [7:0]       OFS_MAKER     = 8'h00;
    localparam logic [7:0]       OFS_FUNCTION  = 8'h02;
    localparam logic [7:0]       OFS_CONTROL   = 8'h04;
    localparam logic [5:0]       DW_IDENT      = OFS_MAKER[7:2];
    localparam logic [5:0]       DW_CONTROL    = OFS_CONTROL[7:2];

    // ************************************************************
    // Command register field positions
    // ************************************************************
    localparam int CMD_IO_SPACE  = 0;
    localparam int CMD_MEM_SPACE = 1;
    localparam int CMD_MASTER    = 2;
    localparam int CMD_SPECIAL   = 3;
    localparam int CMD_WINV      = 4;
    localparam int CMD_PALETTE   = 5;
    localparam int CMD_PARITY    = 6;
    localparam int CMD_STEP      = 7;
    localparam int CMD_SERR      = 8;
    localparam int CMD_B2B       = 9;
    localparam int CMD_INT_DIS   = 10;
    localparam int CMD_RSVD_LO   = 11;
    localparam int CMD_RSVD_HI   = 15;

    // ************************************************************
    // Reset values and writable masks
    // ************************************************************
    localparam logic [15:0] CMD_RESET        = 16'h0000;
    localparam logic [15:0] CMD_WR_MASK_BASE = 16'h0156;
    localparam logic [15:0] CMD_INT_DIS_MASK = 16'h0400;
    localparam logic [15:0] STATUS_PLACEHOLD = 16'h0000;
    localparam logic [31:0] RDATA_RESET      = 32'h0000_0000;
    localparam logic [2:0]  RST_SYNC_RESET   = 3'h0;

    // Arbitrary neutral identity values; the integrator overrides them.
    localparam logic [15:0] MAKER_ID_DEFAULT    = 16'h1A2B;
    localparam logic [15:0] FUNCTION_ID_DEFAULT = 16'h3C4D;

    // ************************************************************
    // Master write command codes
    // ************************************************************
    localparam logic [3:0] BUS_CMD_MEM_WRITE     = 4'h7;
    localparam logic [3:0] BUS_CMD_MEM_WRITE_INV = 4'hF;

endpackage : och_pkg

// ---- core/och_bus_gate.sv ----
/*
 * Registered gating of the function's bus-side actions by the command
 * register enables: interrupt, error drivers, mastering, write command
 * choice and memory-space claim.
 * Assumes all request inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
module och_bus_gate
    import och_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [15:0] command,
    input  wire logic        irq_request,
    input  wire logic        addr_parity_error,
    input  wire logic        data_parity_error,
    input  wire logic        master_request,
    input  wire logic        master_write_inv,
    input  wire logic        mem_decode_hit,
    output logic             interrupt_out,
    output logic             system_error_output_n,
    output logic             system_error_output_oe,
    output logic             parity_error_output_n,
    output logic             parity_error_output_oe,
    output logic             master_grant,
    output logic [3:0]       master_cmd,
    output logic             mem_claim
);

    // ************************************************************
    // Gated outputs
    // ************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            interrupt_out <= 1'b0;
        end else begin
            interrupt_out <= irq_request & ~command[CMD_INT_DIS]; // [R5]
        end
    end

    // Both error pins are open drain style: driven low only while enabled.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            system_error_output_n  <= 1'b0;
            system_error_output_oe <= 1'b0;
            parity_error_output_n  <= 1'b0;
            parity_error_output_oe <= 1'b0;
        end else begin
            system_error_output_n  <= 1'b0;
            system_error_output_oe <= addr_parity_error & command[CMD_SERR]; // [R7]
            parity_error_output_n  <= 1'b0;
            parity_error_output_oe <= data_parity_error & command[CMD_PARITY]; // [R9]
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            master_grant <= 1'b0;
            master_cmd   <= BUS_CMD_MEM_WRITE;
        end else begin
            master_grant <= master_request & command[CMD_MASTER]; // [R13]
            master_cmd   <= (master_write_inv && command[CMD_WINV]) ? // [R11]
                            BUS_CMD_MEM_WRITE_INV : BUS_CMD_MEM_WRITE;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_claim <= 1'b0;
        end else begin
            mem_claim <= mem_decode_hit & command[CMD_MEM_SPACE]; // [R14]
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_int_gate;
        @(posedge clk) disable iff (!reset_n)
        command[CMD_INT_DIS] |=> !interrupt_out;
    endproperty
    a_int_gate: assert property (p_int_gate) else $error("interrupt while disabled"); // [R5]

    property p_serr_gate;
        @(posedge clk) disable iff (!reset_n)
        system_error_output_oe |-> $past(addr_parity_error) && $past(command[CMD_SERR]);
    endproperty
    a_serr_gate: assert property (p_serr_gate) else $error("system error driven"); // [R7]

    property p_perr_gate;
        @(posedge clk) disable iff (!reset_n)
        data_parity_error && !command[CMD_PARITY] |=> !parity_error_output_oe;
    endproperty
    a_perr_gate: assert property (p_perr_gate) else $error("parity error driven"); // [R9]

    property p_winv_gate;
        @(posedge clk) disable iff (!reset_n)
        (master_cmd == BUS_CMD_MEM_WRITE_INV) |-> $past(command[CMD_WINV]);
    endproperty
    a_winv_gate: assert property (p_winv_gate) else $error("invalidate not allowed"); // [R11]

    property p_master_gate;
        @(posedge clk) disable iff (!reset_n)
        master_request |=> master_grant == $past(command[CMD_MASTER]);
    endproperty
    a_master_gate: assert property (p_master_gate) else $error("master grant wrong"); // [R13]

    property p_mem_gate;
        @(posedge clk) disable iff (!reset_n)
        mem_decode_hit |=> mem_claim == $past(command[CMD_MEM_SPACE]);
    endproperty
    a_mem_gate: assert property (p_mem_gate) else $error("memory claim wrong"); // [R14]

endmodule : och_bus_gate

// ---- tb/och_host_model.sv ----
/*
 * Host bridge model that issues configuration reads and writes to the header.
 * Assumes the header answers each request with a one-cycle acknowledge.
 */
`timescale 1ns/1ps
module och_host_model
    import och_pkg::*;
(
    input  wire logic                     clk,
    output logic                          cfg_rd,
    output logic                          cfg_wr,
    output logic      [CFG_DW_ADDR_W-1:0] cfg_dword_addr,
    output logic      [3:0]               cfg_byte_en,
    output logic      [31:0]              cfg_wdata,
    input  wire logic [31:0]              cfg_rdata,
    input  wire logic                     cfg_ack
);
    initial begin
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_dword_addr = '0;
        cfg_byte_en = 4'h0;
        cfg_wdata = 32'h0000_0000;
    end

    // One request per access, addressed by dword with byte enables.
    // Released address, enable and data lines show the inverse and strobes drop, so a late sample cannot look right.
    task automatic cfg_access(input logic wr, input logic [CFG_DW_ADDR_W-1:0] a,
                              input logic [3:0] be, input logic [31:0] d,
                              output logic [31:0] q);
        logic found;
        found = 1'b0;
        q = 32'hXXXX_XXXX;
        @(posedge clk);
        cfg_rd <= ~wr;
        cfg_wr <= wr;
        cfg_dword_addr <= a;
        cfg_byte_en <= be;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_rd <= 1'b0;
        cfg_wr <= 1'b0;
        cfg_dword_addr <= ~a;
        cfg_byte_en <= ~be;
        cfg_wdata <= ~d;
        for (int n = 0; n < 4 && !found; n++) begin
            @(posedge clk);
            if (cfg_ack === 1'b1) begin
                q = cfg_rdata;
                found = 1'b1;
            end
        end
    endtask : cfg_access
endmodule : och_host_model

// ---- tb/ohci_pci_config_header_front_test.sv ----
/*
 * Self-checking bench for the configuration header front.
 * Assumes the default identity parameters and a writable interrupt disable.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module ohci_pci_config_header_front_test
    import och_pkg::*;
;
    logic clk = 1'b0, reset_n = 1'b0;
    logic [2:0] hdr_rst_n = 3'b111;
    logic irq_request = 1'b0, addr_parity_error = 1'b0, data_parity_error = 1'b0;
    logic master_request = 1'b0, master_write_inv = 1'b0, mem_decode_hit = 1'b0;
    logic cfg_rd, cfg_wr, cfg_ack, interrupt_out, serr_n, serr_oe, perr_n, perr_oe;
    logic master_grant, mem_claim;
    logic [3:0] cfg_byte_en, master_cmd;
    logic [CFG_DW_ADDR_W-1:0] cfg_dword_addr;
    logic [31:0] cfg_wdata, cfg_rdata, q;
    int miscompares = 0, checked = 0;

    always #4 clk = ~clk;

    och_host_model i_och_host_model (.clk(clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_dword_addr(cfg_dword_addr), .cfg_byte_en(cfg_byte_en),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));

    och_cfg_header i_och_cfg_header (.clk(clk), .reset_n(reset_n),
        .fundamental_link_reset_n(hdr_rst_n[0]), .global_reset_n(hdr_rst_n[1]),
        .power_on_reset_n(hdr_rst_n[2]), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_dword_addr(cfg_dword_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .irq_request(irq_request),
        .addr_parity_error(addr_parity_error), .data_parity_error(data_parity_error),
        .master_request(master_request), .master_write_inv(master_write_inv),
        .mem_decode_hit(mem_decode_hit), .interrupt_out(interrupt_out),
        .system_error_output_n(serr_n), .system_error_output_oe(serr_oe),
        .parity_error_output_n(perr_n), .parity_error_output_oe(perr_oe),
        .master_grant(master_grant), .master_cmd(master_cmd), .mem_claim(mem_claim));

    // ************************************************************
    // Access helpers
    // ************************************************************
    task automatic wr(input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] unused;
        i_och_host_model.cfg_access(1'b1, a, be, d, unused);
        `CHK($isunknown(unused), 1'b0)
    endtask : wr

    task automatic rd(input logic [5:0] a);
        i_och_host_model.cfg_access(1'b0, a, 4'hF, 32'h0000_0000, q);
    endtask : rd

    // Gating outputs follow their causes one edge later; two edges give margin.
    task automatic set_req(input logic [5:0] v);
        @(posedge clk);
        {irq_request, addr_parity_error, data_parity_error} <= v[5:3];
        {master_request, master_write_inv, mem_decode_hit} <= v[2:0];
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : set_req

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_identity;
        rd(6'h00);
        `CHK(q, {FUNCTION_ID_DEFAULT, MAKER_ID_DEFAULT})
        rd(6'h01);
        `CHK(q, 32'h0000_0000)
        wr(6'h00, 4'hF, 32'hFFFF_FFFF);
        rd(6'h00);
        `CHK(q, {FUNCTION_ID_DEFAULT, MAKER_ID_DEFAULT})
        rd(6'h05);
        `CHK(q, 32'h0000_0000)
    endtask : t_identity

    task automatic t_command_bits;
        wr(6'h01, 4'h3, 32'hFFFF_FFFF);
        rd(6'h01);
        `CHK(q, 32'h0000_0556)
        wr(6'h01, 4'h3, 32'h0000_0000);
        wr(6'h01, 4'h1, 32'h0000_FFFF);
        rd(6'h01);
        `CHK(q, 32'h0000_0056)
        wr(6'h01, 4'h2, 32'h0000_FFFF);
        rd(6'h01);
        `CHK(q, 32'h0000_0556)
    endtask : t_command_bits

    task automatic t_gating;
        wr(6'h01, 4'h3, 32'h0000_0000);
        set_req(6'h3F);
        `CHK({interrupt_out, serr_oe, perr_oe, master_grant, master_cmd, mem_claim}, 9'h10E)
        wr(6'h01, 4'h3, 32'h0000_0556);
        set_req(6'h3F);
        `CHK({interrupt_out, serr_oe, perr_oe, master_grant, master_cmd, mem_claim}, 9'h0FF)
        `CHK({serr_n, perr_n}, 2'h0)
        set_req(6'h00);
        `CHK({interrupt_out, serr_oe, perr_oe, master_grant, master_cmd, mem_claim}, 9'h00E)
        wr(6'h01, 4'h3, 32'h0000_0004);
        set_req(6'h3F);
        `CHK({interrupt_out, serr_oe, perr_oe, master_grant, master_cmd, mem_claim}, 9'h12E)
        set_req(6'h00);
    endtask : t_gating

    task automatic t_header_resets;
        for (int s = 0; s < 3; s++) begin
            wr(6'h01, 4'h3, 32'h0000_0556);
            rd(6'h01);
            `CHK(q, 32'h0000_0556)
            @(posedge clk);
            hdr_rst_n[s] <= 1'b0;
            repeat (5) @(posedge clk);
            wr(6'h01, 4'h3, 32'h0000_0556);
            rd(6'h01);
            `CHK(q, 32'h0000_0000)
            @(posedge clk);
            hdr_rst_n <= 3'b111;
            repeat (5) @(posedge clk);
            rd(6'h00);
            `CHK(q, {FUNCTION_ID_DEFAULT, MAKER_ID_DEFAULT})
        end
    endtask : t_header_resets

    task automatic report_and_stop;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (5) @(posedge clk);
        t_identity();
        t_command_bits();
        t_gating();
        t_header_resets();
        report_and_stop();
    end

    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
endmodule : ohci_pci_config_header_front_test
